// ---- verilog/fbank_pkg.sv ----
package fbank_pkg;
  // register offsets (on the plain 4-bit address port)
  localparam logic [3:0] OFS_SCRATCH = 4'h7;
  localparam logic [3:0] OFS_MODEM_STATUS = 4'h6;
  localparam logic [3:0] OFS_DIV_LOW = 4'h0;
  localparam logic [3:0] OFS_DIV_HIGH = 4'h1;
  localparam logic [3:0] OFS_TX_SPACE = 4'h8;
  localparam logic [3:0] OFS_RX_FILL = 4'h9;
  localparam logic [3:0] OFS_ENH_CTRL = 4'h2;
  localparam logic [3:0] OFS_IER = 4'h3;
  localparam logic [3:0] OFS_ISR = 4'h4;
  localparam logic [3:0] OFS_FCR = 4'h5;
  localparam logic [3:0] OFS_MCR = 4'hA;
  localparam logic [3:0] OFS_XON1 = 4'hB;
  localparam logic [3:0] OFS_XON2 = 4'hC;
  localparam logic [3:0] OFS_XOFF1 = 4'hD;
  localparam logic [3:0] OFS_SECOND_STOP_CHAR = 4'hE;
  // bank field codes
  localparam logic [1:0] BANK_GENERAL = 2'h0;
  localparam logic [1:0] BANK_EXTRA1 = 2'h1;
  localparam logic [1:0] BANK_EXTRA2 = 2'h2;
  localparam logic [1:0] BANK_RSVD = 2'h3;
  // field positions
  localparam int BANK_LSB = 1;
  localparam int CNT_EN_BIT = 0;
  localparam int ENH_AUTO_CTS = 7;
  localparam int ENH_AUTO_RTS = 6;
  localparam int ENH_SPECIAL = 5;
  localparam int ENH_LATCH = 4;
  localparam int ISR_SPECIAL = 4;
  localparam int MCR_RTS = 1;
  localparam logic [7:0] IER_ENH_MASK = 8'hF0;
  localparam logic [7:0] ISR_ENH_MASK = 8'h30;
  localparam logic [7:0] FCR_ENH_MASK = 8'h30;
  localparam logic [7:0] MCR_ENH_MASK = 8'hE0;
  localparam logic [7:0] ZERO8 = 8'h00;
  // transmit flow choice, bits 3:2
  localparam logic [1:0] TXF_NONE = 2'h0;
  localparam logic [1:0] TXF_PAIR1 = 2'h2;
  localparam logic [1:0] TXF_PAIR2 = 2'h1;
  localparam logic [1:0] TXF_BOTH = 2'h3;

  typedef struct packed {
    logic [1:0] bank;
    logic cnt_en;
    logic [7:0] scratch;
    logic [15:0] divisor;
    logic [7:0] enh;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] interrupt_status_reg;
    logic [7:0] fifo_control_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] xon1;
    logic [7:0] xon2;
    logic [7:0] xoff1;
    logic [7:0] second_stop_char;
    logic rts_auto;
    logic [7:0] rd_data;
    logic tx_halt;
    logic rts_out;
    logic special_hit;
    logic [1:0] tx_sel;
    logic [1:0] rx_sel;
    logic dual_rx;
  } state_s;
endpackage : fbank_pkg

// ---- verilog/uart_feature_bank.sv ----
// Behaviour
// R1: decode two-bit bank field, 11 reserved
// R2: level counters readable only with access bit
// R3: bank field nonzero blocks counter access
// R4: scratch byte stores and returns writes
// R5: divisor is high and low bytes
// R6: transmit count shows free FIFO entries
// R7: receive count shows held characters
// R8: auto clear-to-send halts transmit while high
// R9: auto request-to-send rises at next trigger
// R10: request-to-send falls below lower trigger
// R11: flow control off: software drives request-to-send
// R12: special char match sets status bit 4
// R13: character bit 0 aligns received LSB
// R14: software clears select bits before detection
// R15: enhanced bit opens enhanced field writes
// R16: enhanced bit clear latches enhanced fields
// R17: select bits choose Xon/Xoff combinations
// R18: dual mode concatenates two character registers
// R19: select bits reset to zero
// R20: bank register shares modem status address
// R21: bits 3:2 transmit, 1:0 receive choice
// R22: software avoids flow characters as payload
// R23: reserved bank code writes ignored
`timescale 1ns/1ps
`default_nettype none
module uart_feature_bank #(
  parameter int CNT_W = 8
) (
  input wire logic CLK, // 10 MHz clock
  input wire logic RESET, // async reset, active high
  input wire logic [3:0] ADDR, // register address
  input wire logic [7:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [7:0] RDATA, // read data, cycle after RD
  input wire logic [7:0] MODEM_STATUS, // modem status byte
  input wire logic [CNT_W-1:0] TX_SPACE, // free transmit entries
  input wire logic [CNT_W-1:0] RX_FILL, // held receive characters
  input wire logic RX_ABOVE_TRIG, // receive fill at next trigger
  input wire logic RX_BELOW_LOW, // receive fill below lower trigger
  input wire logic CTS_N, // clear-to-send, active low
  input wire logic RX_VALID, // received character pulse
  input wire logic [7:0] RX_CHAR, // received character
  output logic [1:0] BANK, // selected register set
  output logic [15:0] DIVISOR, // baud divisor
  output logic TX_HALT, // transmit stall
  output logic RTS_OUT, // request-to-send level
  output logic SPECIAL_HIT, // special char match pulse
  output logic [1:0] TX_FLOW_SEL, // transmit Xon/Xoff choice
  output logic [1:0] RX_FLOW_SEL, // receive compare choice
  output logic DUAL_RX // two-character compare sequence
);
  fbank_pkg::state_s st_ff;
  fbank_pkg::state_s nxt_st;
  logic [15:0] xoff_pair;
  logic rx_match;

  // special char compare, bit 0 aligned with received LSB
  assign rx_match = (RX_CHAR == st_ff.second_stop_char); // [R13]
  assign xoff_pair = {st_ff.xoff1, st_ff.second_stop_char}; // [R18]

  // next-state logic
  always_comb begin
    logic gen;
    logic enh_open;
    gen = (st_ff.bank == fbank_pkg::BANK_GENERAL); // [R1]
    enh_open = st_ff.enh[fbank_pkg::ENH_LATCH]; // [R15]
    nxt_st = st_ff;
    nxt_st.special_hit = 1'b0;
    nxt_st.rd_data = fbank_pkg::ZERO8;
    if (WR) begin
      unique case (ADDR)
        fbank_pkg::OFS_MODEM_STATUS: begin
          if (WDATA[fbank_pkg::BANK_LSB +: 2] != fbank_pkg::BANK_RSVD) begin // [R23]
            nxt_st.bank = WDATA[fbank_pkg::BANK_LSB +: 2]; // [R20] [R1]
            nxt_st.cnt_en = WDATA[fbank_pkg::CNT_EN_BIT];
          end
        end
        fbank_pkg::OFS_SCRATCH: nxt_st.scratch = WDATA; // [R4]
        fbank_pkg::OFS_DIV_LOW: nxt_st.divisor[7:0] = WDATA; // [R5]
        fbank_pkg::OFS_DIV_HIGH: nxt_st.divisor[15:8] = WDATA; // [R5]
        fbank_pkg::OFS_ENH_CTRL: nxt_st.enh = WDATA;
        fbank_pkg::OFS_IER: nxt_st.interrupt_enable_reg = enh_open ? WDATA
          : ((WDATA & ~fbank_pkg::IER_ENH_MASK) | (st_ff.interrupt_enable_reg & fbank_pkg::IER_ENH_MASK)); // [R16]
        fbank_pkg::OFS_ISR: nxt_st.interrupt_status_reg = enh_open ? WDATA
          : ((WDATA & ~fbank_pkg::ISR_ENH_MASK) | (st_ff.interrupt_status_reg & fbank_pkg::ISR_ENH_MASK)); // [R16]
        fbank_pkg::OFS_FCR: nxt_st.fifo_control_reg = enh_open ? WDATA
          : ((WDATA & ~fbank_pkg::FCR_ENH_MASK) | (st_ff.fifo_control_reg & fbank_pkg::FCR_ENH_MASK)); // [R16]
        fbank_pkg::OFS_MCR: nxt_st.modem_control_reg = enh_open ? WDATA
          : ((WDATA & ~fbank_pkg::MCR_ENH_MASK) | (st_ff.modem_control_reg & fbank_pkg::MCR_ENH_MASK)); // [R16]
        fbank_pkg::OFS_XON1: nxt_st.xon1 = WDATA;
        fbank_pkg::OFS_XON2: nxt_st.xon2 = WDATA;
        fbank_pkg::OFS_XOFF1: nxt_st.xoff1 = WDATA;
        fbank_pkg::OFS_SECOND_STOP_CHAR: nxt_st.second_stop_char = WDATA;
        default: ;
      endcase
    end
    // read mux
    if (RD) begin
      unique case (ADDR)
        fbank_pkg::OFS_MODEM_STATUS: nxt_st.rd_data = MODEM_STATUS; // [R20]
        fbank_pkg::OFS_SCRATCH: nxt_st.rd_data = st_ff.scratch; // [R4]
        fbank_pkg::OFS_DIV_LOW: nxt_st.rd_data = st_ff.divisor[7:0];
        fbank_pkg::OFS_DIV_HIGH: nxt_st.rd_data = st_ff.divisor[15:8];
        fbank_pkg::OFS_ENH_CTRL: nxt_st.rd_data = st_ff.enh;
        fbank_pkg::OFS_IER: nxt_st.rd_data = st_ff.interrupt_enable_reg;
        fbank_pkg::OFS_ISR: nxt_st.rd_data = st_ff.interrupt_status_reg;
        fbank_pkg::OFS_FCR: nxt_st.rd_data = st_ff.fifo_control_reg;
        fbank_pkg::OFS_MCR: nxt_st.rd_data = st_ff.modem_control_reg;
        fbank_pkg::OFS_XON1: nxt_st.rd_data = st_ff.xon1;
        fbank_pkg::OFS_XON2: nxt_st.rd_data = st_ff.xon2;
        fbank_pkg::OFS_XOFF1: nxt_st.rd_data = st_ff.xoff1;
        fbank_pkg::OFS_SECOND_STOP_CHAR: nxt_st.rd_data = st_ff.second_stop_char;
        fbank_pkg::OFS_TX_SPACE:
          if (gen && st_ff.cnt_en) nxt_st.rd_data = 8'(TX_SPACE); // [R2] [R3] [R6]
        fbank_pkg::OFS_RX_FILL:
          if (gen && st_ff.cnt_en) nxt_st.rd_data = 8'(RX_FILL); // [R2] [R3] [R7]
        default: ;
      endcase
    end
    // auto clear-to-send stall
    nxt_st.tx_halt = st_ff.enh[fbank_pkg::ENH_AUTO_CTS] & CTS_N; // [R8]
    // auto request-to-send hysteresis
    if (RX_ABOVE_TRIG) nxt_st.rts_auto = 1'b1; // [R9]
    else if (RX_BELOW_LOW) nxt_st.rts_auto = 1'b0; // [R10]
    nxt_st.rts_out = st_ff.enh[fbank_pkg::ENH_AUTO_RTS] ? st_ff.rts_auto
      : st_ff.modem_control_reg[fbank_pkg::MCR_RTS]; // [R9] [R11]
    // special character detect; hardware set wins over software write
    if (RX_VALID && st_ff.enh[fbank_pkg::ENH_SPECIAL] && rx_match) begin // [R12]
      nxt_st.interrupt_status_reg[fbank_pkg::ISR_SPECIAL] = 1'b1;
      nxt_st.special_hit = 1'b1;
    end
    // software flow selection decode
    nxt_st.tx_sel = st_ff.enh[3:2]; // [R17] [R21]
    nxt_st.rx_sel = st_ff.enh[1:0]; // [R21]
    nxt_st.dual_rx = (st_ff.enh[1:0] == 2'h3) && (xoff_pair != 16'h0000); // [R18]
  end

  // state register; select bits clear at reset
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st_ff <= '0; // [R19]
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign RDATA = st_ff.rd_data;
  assign BANK = st_ff.bank;
  assign DIVISOR = st_ff.divisor;
  assign TX_HALT = st_ff.tx_halt;
  assign RTS_OUT = st_ff.rts_out;
  assign SPECIAL_HIT = st_ff.special_hit;
  assign TX_FLOW_SEL = st_ff.tx_sel;
  assign RX_FLOW_SEL = st_ff.rx_sel;
  assign DUAL_RX = st_ff.dual_rx;

  property p_cnt_gate;
    @(posedge CLK) disable iff (RESET)
    (RD && ADDR == fbank_pkg::OFS_TX_SPACE && (st_ff.bank != fbank_pkg::BANK_GENERAL
      || !st_ff.cnt_en)) |=> (RDATA == fbank_pkg::ZERO8);
  endproperty
  a_cnt_gate: assert property (p_cnt_gate) else $error("counter read not gated"); // [R3]

  property p_cnt_read;
    @(posedge CLK) disable iff (RESET)
    (RD && ADDR == fbank_pkg::OFS_RX_FILL && st_ff.bank == fbank_pkg::BANK_GENERAL
      && st_ff.cnt_en) |=> (RDATA == $past(8'(RX_FILL)));
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("receive count wrong"); // [R2]

  property p_scratch;
    @(posedge CLK) disable iff (RESET)
    (WR && ADDR == fbank_pkg::OFS_SCRATCH) ##1 (RD && ADDR == fbank_pkg::OFS_SCRATCH
      && !WR) |=> (RDATA == $past(WDATA, 2));
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch mismatch"); // [R4]

  property p_rsvd_bank;
    @(posedge CLK) disable iff (RESET)
    (WR && ADDR == fbank_pkg::OFS_MODEM_STATUS && WDATA[2:1] == fbank_pkg::BANK_RSVD)
      |=> $stable(BANK);
  endproperty
  a_rsvd_bank: assert property (p_rsvd_bank) else $error("reserved bank taken"); // [R23]

  property p_cts;
    @(posedge CLK) disable iff (RESET)
    (st_ff.enh[fbank_pkg::ENH_AUTO_CTS] && CTS_N) |=> TX_HALT;
  endproperty
  a_cts: assert property (p_cts) else $error("transmit not halted"); // [R8]

  property p_rts_soft;
    @(posedge CLK) disable iff (RESET)
    (!st_ff.enh[fbank_pkg::ENH_AUTO_RTS]) |=> (RTS_OUT == $past(st_ff.modem_control_reg[fbank_pkg::MCR_RTS]));
  endproperty
  a_rts_soft: assert property (p_rts_soft) else $error("rts not software driven"); // [R11]

  property p_special;
    @(posedge CLK) disable iff (RESET)
    (RX_VALID && st_ff.enh[fbank_pkg::ENH_SPECIAL] && RX_CHAR == st_ff.second_stop_char)
      |=> (SPECIAL_HIT && st_ff.interrupt_status_reg[fbank_pkg::ISR_SPECIAL]);
  endproperty
  a_special: assert property (p_special) else $error("special char missed"); // [R12]

  property p_latch;
    @(posedge CLK) disable iff (RESET)
    (WR && ADDR == fbank_pkg::OFS_IER && !st_ff.enh[fbank_pkg::ENH_LATCH])
      |=> (st_ff.interrupt_enable_reg[7:4] == $past(st_ff.interrupt_enable_reg[7:4]));
  endproperty
  a_latch: assert property (p_latch) else $error("latched bits changed"); // [R16]

  // bank register and counter gating
  property p_bank_take;
    @(posedge CLK) disable iff (RESET)
    (WR && ADDR == fbank_pkg::OFS_MODEM_STATUS
      && WDATA[fbank_pkg::BANK_LSB +: 2] != fbank_pkg::BANK_RSVD)
      |=> (BANK == $past(WDATA[fbank_pkg::BANK_LSB +: 2]));
  endproperty
  a_bank_take: assert property (p_bank_take) else $error("bank write lost"); // [R1]

  property p_rsvd_cnt;
    @(posedge CLK) disable iff (RESET)
    (WR && ADDR == fbank_pkg::OFS_MODEM_STATUS
      && WDATA[fbank_pkg::BANK_LSB +: 2] == fbank_pkg::BANK_RSVD) |=> $stable(st_ff.cnt_en);
  endproperty
  a_rsvd_cnt: assert property (p_rsvd_cnt) else $error("reserved write took access bit"); // [R23]

  property p_tx_read;
    @(posedge CLK) disable iff (RESET)
    (RD && ADDR == fbank_pkg::OFS_TX_SPACE && st_ff.bank == fbank_pkg::BANK_GENERAL
      && st_ff.cnt_en) |=> (RDATA == $past(8'(TX_SPACE)));
  endproperty
  a_tx_read: assert property (p_tx_read) else $error("transmit count wrong"); // [R6]

  property p_rx_gate;
    @(posedge CLK) disable iff (RESET)
    (RD && ADDR == fbank_pkg::OFS_RX_FILL && (st_ff.bank != fbank_pkg::BANK_GENERAL
      || !st_ff.cnt_en)) |=> (RDATA == fbank_pkg::ZERO8);
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("receive count not gated"); // [R2]

  property p_ms_read;
    @(posedge CLK) disable iff (RESET)
    (RD && ADDR == fbank_pkg::OFS_MODEM_STATUS) |=> (RDATA == $past(MODEM_STATUS));
  endproperty
  a_ms_read: assert property (p_ms_read) else $error("modem status read wrong"); // [R20]

  property p_ms_write;
    @(posedge CLK) disable iff (RESET)
    (WR && !RD && ADDR == fbank_pkg::OFS_MODEM_STATUS) |=> (RDATA == fbank_pkg::ZERO8);
  endproperty
  a_ms_write: assert property (p_ms_write) else $error("bank write echoed"); // [R20]

  // plain storage registers
  property p_div_low;
    @(posedge CLK) disable iff (RESET)
    (WR && ADDR == fbank_pkg::OFS_DIV_LOW) |=> (DIVISOR[7:0] == $past(WDATA));
  endproperty
  a_div_low: assert property (p_div_low) else $error("divisor low wrong"); // [R5]

  property p_div_high;
    @(posedge CLK) disable iff (RESET)
    (WR && ADDR == fbank_pkg::OFS_DIV_HIGH) |=> (DIVISOR[15:8] == $past(WDATA));
  endproperty
  a_div_high: assert property (p_div_high) else $error("divisor high wrong"); // [R5]

  property p_scratch_keep;
    @(posedge CLK) disable iff (RESET)
    (WR && ADDR != fbank_pkg::OFS_SCRATCH) |=> $stable(st_ff.scratch);
  endproperty
  a_scratch_keep: assert property (p_scratch_keep) else $error("scratch disturbed"); // [R4]

  // hardware flow control
  property p_cts_go;
    @(posedge CLK) disable iff (RESET)
    (st_ff.enh[fbank_pkg::ENH_AUTO_CTS] && !CTS_N) |=> !TX_HALT;
  endproperty
  a_cts_go: assert property (p_cts_go) else $error("transmit not resumed"); // [R8]

  property p_cts_off;
    @(posedge CLK) disable iff (RESET)
    (!st_ff.enh[fbank_pkg::ENH_AUTO_CTS]) |=> !TX_HALT;
  endproperty
  a_cts_off: assert property (p_cts_off) else $error("halt while auto off"); // [R8]

  property p_rts_rise;
    @(posedge CLK) disable iff (RESET)
    RX_ABOVE_TRIG |=> st_ff.rts_auto;
  endproperty
  a_rts_rise: assert property (p_rts_rise) else $error("rts not raised"); // [R9]

  property p_rts_auto;
    @(posedge CLK) disable iff (RESET)
    st_ff.enh[fbank_pkg::ENH_AUTO_RTS] |=> (RTS_OUT == $past(st_ff.rts_auto));
  endproperty
  a_rts_auto: assert property (p_rts_auto) else $error("rts not automatic"); // [R9]

  property p_rts_fall;
    @(posedge CLK) disable iff (RESET)
    (!RX_ABOVE_TRIG && RX_BELOW_LOW) |=> !st_ff.rts_auto;
  endproperty
  a_rts_fall: assert property (p_rts_fall) else $error("rts not lowered"); // [R10]

  // special character and enhanced latch
  property p_special_off;
    @(posedge CLK) disable iff (RESET)
    (RX_VALID && !st_ff.enh[fbank_pkg::ENH_SPECIAL]) |=> !SPECIAL_HIT;
  endproperty
  a_special_off: assert property (p_special_off) else $error("hit while detect off"); // [R12]

  property p_special_miss;
    @(posedge CLK) disable iff (RESET)
    (RX_VALID && RX_CHAR != st_ff.second_stop_char) |=> !SPECIAL_HIT;
  endproperty
  a_special_miss: assert property (p_special_miss) else $error("false special hit"); // [R13]

  property p_open;
    @(posedge CLK) disable iff (RESET)
    (WR && ADDR == fbank_pkg::OFS_IER && st_ff.enh[fbank_pkg::ENH_LATCH])
      |=> (st_ff.interrupt_enable_reg == $past(WDATA));
  endproperty
  a_open: assert property (p_open) else $error("open write refused"); // [R15]

  property p_mcr_latch;
    @(posedge CLK) disable iff (RESET)
    (WR && ADDR == fbank_pkg::OFS_MCR && !st_ff.enh[fbank_pkg::ENH_LATCH])
      |=> (st_ff.modem_control_reg[7:5] == $past(st_ff.modem_control_reg[7:5]));
  endproperty
  a_mcr_latch: assert property (p_mcr_latch) else $error("latched modem bits changed"); // [R16]

  property p_fcr_latch;
    @(posedge CLK) disable iff (RESET)
    (WR && ADDR == fbank_pkg::OFS_FCR && !st_ff.enh[fbank_pkg::ENH_LATCH])
      |=> (st_ff.fifo_control_reg[5:4] == $past(st_ff.fifo_control_reg[5:4]));
  endproperty
  a_fcr_latch: assert property (p_fcr_latch) else $error("latched fifo bits changed"); // [R16]

  // software flow selection
  property p_enh_store;
    @(posedge CLK) disable iff (RESET)
    (WR && ADDR == fbank_pkg::OFS_ENH_CTRL) |=> (st_ff.enh == $past(WDATA));
  endproperty
  a_enh_store: assert property (p_enh_store) else $error("feature write lost"); // [R17]

  property p_tx_sel;
    @(posedge CLK) disable iff (RESET)
    1'b1 |=> (TX_FLOW_SEL == $past(st_ff.enh[3:2]));
  endproperty
  a_tx_sel: assert property (p_tx_sel) else $error("transmit choice wrong"); // [R21]

  property p_rx_sel;
    @(posedge CLK) disable iff (RESET)
    1'b1 |=> (RX_FLOW_SEL == $past(st_ff.enh[1:0]));
  endproperty
  a_rx_sel: assert property (p_rx_sel) else $error("receive choice wrong"); // [R17]

  property p_dual;
    @(posedge CLK) disable iff (RESET)
    (st_ff.enh[1:0] != 2'h3) |=> !DUAL_RX;
  endproperty
  a_dual: assert property (p_dual) else $error("dual compare unexpected"); // [R18]
endmodule : uart_feature_bank
`default_nettype wire

// ---- sim/serial_peer_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model (
  input wire logic CLK, // bench clock
  input wire logic hold_req, // peer wants our transmitter stopped
  input wire logic send_req, // one-cycle request to deliver a character
  input wire logic [7:0] char_in, // character to deliver
  output logic CTS_N, // clear-to-send, active low
  output logic RX_VALID, // character strobe
  output logic [7:0] RX_CHAR, // received character
  output logic [7:0] MODEM_STATUS // modem status byte
);
  // data is inverted outside the strobe so stale values never match
  always @(posedge CLK) begin
    CTS_N <= hold_req;
    RX_VALID <= send_req;
    RX_CHAR <= send_req ? char_in : ~char_in;
    MODEM_STATUS <= {3'h0, ~hold_req, 4'h9}; // cts status is inverted pin
  end
endmodule : serial_peer_model
`default_nettype wire

// ---- sim/uart_feature_bank_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module uart_feature_bank_tb_top;
  logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, above = 1'b0, below = 1'b0;
  logic hold = 1'b0, send = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, tx_space = 8'h3C, rx_fill = 8'h07, chr = 8'h00, d, ms, rxc;
  logic [7:0] rdata;
  logic [1:0] bank, txs, rxs;
  logic [15:0] div;
  logic cts_n, rxv, halt, rts, hit, dual, h;
  int n_errors = 0, check_count = 0, cycles = 0;
  // dut and far-side peer
  uart_feature_bank u_dut (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .MODEM_STATUS(ms), .TX_SPACE(tx_space), .RX_FILL(rx_fill),
    .RX_ABOVE_TRIG(above), .RX_BELOW_LOW(below), .CTS_N(cts_n), .RX_VALID(rxv),
    .RX_CHAR(rxc), .BANK(bank), .DIVISOR(div), .TX_HALT(halt), .RTS_OUT(rts),
    .SPECIAL_HIT(hit), .TX_FLOW_SEL(txs), .RX_FLOW_SEL(rxs), .DUAL_RX(dual));
  serial_peer_model u_peer (.CLK(clk), .hold_req(hold), .send_req(send), .char_in(chr),
    .CTS_N(cts_n), .RX_VALID(rxv), .RX_CHAR(rxc), .MODEM_STATUS(ms));
  // 100 ns clock and cycle ceiling
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] v, output logic [7:0] r);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 r = rdata;
  endtask : wr_rd
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle
  task automatic t_regs();
    chk(txs, 2'h0);
    chk(rxs, 2'h0);
    rreg(fbank_pkg::OFS_ENH_CTRL, d);
    chk(d, 8'h00);
    wreg(fbank_pkg::OFS_SCRATCH, 8'hC3);
    wreg(fbank_pkg::OFS_DIV_LOW, 8'h34);
    wreg(fbank_pkg::OFS_DIV_HIGH, 8'h12);
    rreg(fbank_pkg::OFS_SCRATCH, d);
    chk(d, 8'hC3);
    chk(div[15:8], 8'h12);
    chk(div[7:0], 8'h34);
    rreg(4'hF, d);
    chk(d, 8'h00);
    wr_rd(fbank_pkg::OFS_SCRATCH, 8'h5A, d);
    chk(d, 8'h5A);
  endtask : t_regs
  task automatic t_bank();
    for (int i = 0; i < 3; i++) begin
      wreg(fbank_pkg::OFS_MODEM_STATUS, {5'h00, i[1:0], 1'b0});
      settle();
      chk(bank, i[1:0]);
    end
    rreg(fbank_pkg::OFS_MODEM_STATUS, d);
    chk(d, 8'h19);
    wreg(fbank_pkg::OFS_MODEM_STATUS, 8'h01);
    rreg(fbank_pkg::OFS_TX_SPACE, d);
    chk(d, 8'h3C);
    rreg(fbank_pkg::OFS_RX_FILL, d);
    chk(d, 8'h07);
    wreg(fbank_pkg::OFS_MODEM_STATUS, 8'h03);
    wreg(fbank_pkg::OFS_MODEM_STATUS, 8'hFF);
    settle();
    chk(bank, 2'h1);
    rreg(fbank_pkg::OFS_TX_SPACE, d);
    chk(d, 8'h00);
    wreg(fbank_pkg::OFS_MODEM_STATUS, 8'h00);
    rreg(fbank_pkg::OFS_RX_FILL, d);
    chk(d, 8'h00);
  endtask : t_bank
  task automatic t_flow();
    wreg(fbank_pkg::OFS_ENH_CTRL, 8'h80);
    hold <= 1'b1;
    settle();
    chk(halt, 1'b1);
    hold <= 1'b0;
    settle();
    chk(halt, 1'b0);
    wreg(fbank_pkg::OFS_ENH_CTRL, 8'h40);
    above <= 1'b1;
    settle();
    chk(rts, 1'b1);
    above <= 1'b0;
    below <= 1'b1;
    settle();
    chk(rts, 1'b0);
    wreg(fbank_pkg::OFS_ENH_CTRL, 8'h00);
    wreg(fbank_pkg::OFS_MCR, 8'h02);
    settle();
    chk(rts, 1'b1);
    below <= 1'b0;
  endtask : t_flow
  task automatic pass_char(input logic [7:0] c, output logic seen);
    @(posedge clk);
    send <= 1'b1;
    chr <= c;
    @(posedge clk);
    send <= 1'b0;
    seen = 1'b0;
    repeat (4) begin
      @(posedge clk);
      #1 seen = seen | hit;
    end
  endtask : pass_char
  task automatic t_special();
    wreg(fbank_pkg::OFS_SECOND_STOP_CHAR, 8'hA5);
    wreg(fbank_pkg::OFS_ENH_CTRL, 8'h20);
    pass_char(8'hA4, h);
    chk(h, 1'b0);
    pass_char(8'hA5, h);
    chk(h, 1'b1);
    rreg(fbank_pkg::OFS_ISR, d);
    chk(d[4], 1'b1);
  endtask : t_special
  task automatic t_latch();
    wreg(fbank_pkg::OFS_ENH_CTRL, 8'h00);
    wreg(fbank_pkg::OFS_IER, 8'hFF);
    rreg(fbank_pkg::OFS_IER, d);
    chk(d, 8'h0F);
    wreg(fbank_pkg::OFS_ENH_CTRL, 8'h10);
    wreg(fbank_pkg::OFS_IER, 8'hFF);
    rreg(fbank_pkg::OFS_IER, d);
    chk(d, 8'hFF);
    wreg(fbank_pkg::OFS_ENH_CTRL, 8'h00);
    wreg(fbank_pkg::OFS_IER, 8'h00);
    rreg(fbank_pkg::OFS_IER, d);
    chk(d, 8'hF0);
  endtask : t_latch
  task automatic t_select();
    for (int i = 0; i < 16; i++) begin
      wreg(fbank_pkg::OFS_ENH_CTRL, {4'h0, i[3:0]});
      settle();
      chk({txs, rxs}, i[3:0]);
      chk(dual, i[1:0] == 2'h3);
    end
  endtask : t_select
  // reset for 8 cycles, then every scenario in turn
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_bank();
    t_flow();
    t_special();
    t_latch();
    t_select();
    complete_run();
  end
endmodule : uart_feature_bank_tb_top
`default_nettype wire
